// *** rtl/ldpwm_top.sv ***
// APB register file and dimming source selection of the LED dimming PWM block.
//
// Operation
// - Two-bit fields choose dimming source and internal generator rate.
// - Channel 1 duty drives the output only while internal dimming is chosen.
// - Duty is 10-bit unsigned; 1023 keeps output always on, else proportional.
// - Enhanced variant: bits 5:4 enable zero-cross comparator per channel.
`timescale 1ns/1ps
module ldpwm_top #(
	parameter bit ENHANCED = 1'b1,
	parameter int DIV_RATE0 = ldpwm_pkg::DIM_DIV_RATE0,
	parameter int DIV_RATE1 = ldpwm_pkg::DIM_DIV_RATE1,
	parameter int DIV_RATE2 = ldpwm_pkg::DIM_DIV_RATE2,
	parameter int DIV_RATE3 = ldpwm_pkg::DIM_DIV_RATE3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_dim_ch1,
	output logic dim_ch1,
	output logic [1:0] zero_cross_high_voltage_enable,
	output logic [1:0] booster_multiphase_select,
	output logic [3:0] gate_drive_voltage_target
);

	// ----------------------------------------------------------------
	// Elaboration checks.
	// ----------------------------------------------------------------
	localparam int DIV_MAX = (1 << ldpwm_pkg::DIV_W) - 1;

	if (DIV_RATE0 < 1 || DIV_RATE1 < 1 || DIV_RATE2 < 1 || DIV_RATE3 < 1) begin : g_div_lo
		$error("Dimming step dividers must be at least one.");
	end
	if (DIV_RATE0 > DIV_MAX || DIV_RATE1 > DIV_MAX || DIV_RATE2 > DIV_MAX ||
		DIV_RATE3 > DIV_MAX) begin : g_div_hi
		$error("Dimming step dividers exceed the divider counter width.");
	end

	// ----------------------------------------------------------------
	// Functions.
	// ----------------------------------------------------------------
	// Reload value of the step divider for a rate code.
	function automatic logic [ldpwm_pkg::DIV_W-1:0] rate_reload(input logic [1:0] sel);
		int d;
		case (sel)
			2'h0: d = DIV_RATE0;
			2'h1: d = DIV_RATE1;
			2'h2: d = DIV_RATE2;
			default: d = DIV_RATE3;
		endcase
		return ldpwm_pkg::DIV_W'(d - 1);
	endfunction

	// Byte-lane masked update of a 10-bit register.
	function automatic logic [9:0] lane_write(input logic [9:0] cur, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [9:0] nv;
		nv = cur;
		if (strb[0]) begin
			nv[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			nv[9:8] = wd[9:8];
		end
		return nv;
	endfunction

	// ----------------------------------------------------------------
	// APB decode.
	// ----------------------------------------------------------------
	logic [7:0] idx;
	logic hit_cfg;
	logic hit_duty;
	logic hit_stat;
	logic mapped;
	logic access_done;

	assign idx = paddr[ldpwm_pkg::ADDR_LSB +: 8];
	assign hit_cfg = (idx == ldpwm_pkg::IDX_DIM_GENERAL_CONFIG) && (paddr[11:10] == 2'h0);
	assign hit_duty = (idx == ldpwm_pkg::IDX_DUTY_LEVEL_CHANNEL_ONE) && (paddr[11:10] == 2'h0);
	assign hit_stat = (idx == ldpwm_pkg::IDX_DIM_STATUS) && (paddr[11:10] == 2'h0);
	assign mapped = hit_cfg || hit_duty || hit_stat;
	// Transfers complete on the edge where the registered ready is already high.
	assign access_done = psel && penable && pready;

	// ----------------------------------------------------------------
	// Configuration registers.
	// ----------------------------------------------------------------
	ldpwm_pkg::ldpwm_cfg_s cfg_q;
	logic [ldpwm_pkg::DUTY_W-1:0] duty_q;

	// Bits 5:4 are stored unchanged on either variant; the base variant relies on
	// software leaving the multiphase field at zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= ldpwm_pkg::DIM_GENERAL_CONFIG_RST;
		end else if (access_done && pwrite && hit_cfg) begin
			cfg_q <= lane_write(cfg_q, pwdata, pstrb);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duty_q <= ldpwm_pkg::DUTY_LEVEL_CHANNEL_ONE_RST;
		end else if (access_done && pwrite && hit_duty) begin
			duty_q <= lane_write(duty_q, pwdata, pstrb);
		end
	end

	// ----------------------------------------------------------------
	// APB answer.
	// ----------------------------------------------------------------
	logic ext_sel;
	logic int_level;
	logic [9:0] status;

	assign ext_sel = (cfg_q.dimming_source_select != ldpwm_pkg::DIMMING_SOURCE_SELECT_INTERNAL);

	always_comb begin
		status = '0;
		status[ldpwm_pkg::STAT_LEVEL_BIT] = dim_ch1;
		status[ldpwm_pkg::STAT_EXT_BIT] = ext_sel;
		status[ldpwm_pkg::STAT_ENH_BIT] = ENHANCED;
	end

	// One wait state: ready is low in the first access cycle, high in the second and falls after it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && penable && !pready && !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && penable && !pready && !pwrite) begin
			if (hit_cfg) begin
				prdata <= {22'h000000, cfg_q};
			end else if (hit_duty) begin
				prdata <= {22'h000000, duty_q};
			end else if (hit_stat) begin
				prdata <= {22'h000000, status};
			end else begin
				prdata <= '0;
			end
		end else begin
			prdata <= '0;
		end
	end

	// ----------------------------------------------------------------
	// Dimming rate divider.
	// ----------------------------------------------------------------
	logic [ldpwm_pkg::DIV_W-1:0] div_cnt_q;
	logic step_en_q;

	// A rate change takes effect at the next reload, so a running step is finished first.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_q <= '0;
			step_en_q <= 1'b0;
		end else if (div_cnt_q == '0) begin
			div_cnt_q <= rate_reload(cfg_q.internal_dim_rate_select);
			step_en_q <= 1'b1;
		end else begin
			div_cnt_q <= div_cnt_q - {{(ldpwm_pkg::DIV_W-1){1'b0}}, 1'b1};
			step_en_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Internal generator and source selection.
	// ----------------------------------------------------------------
	ldpwm_dim_gen #(
		.W(ldpwm_pkg::DUTY_W)
	) u_gen (
		.clk(pclk),
		.rst_n(presetn),
		.step_en(step_en_q),
		.duty(duty_q),
		.level_q(int_level),
		.period_start_q()
	);

	// With external dimming the duty setting is ignored entirely.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dim_ch1 <= 1'b0;
		end else begin
			dim_ch1 <= ext_sel ? ext_dim_ch1 : int_level;
		end
	end

	// ----------------------------------------------------------------
	// Analog control outputs.
	// ----------------------------------------------------------------
	assign gate_drive_voltage_target = cfg_q.gate_drive_voltage_target;

	// The comparator enable is a plain level, independent of the LED voltage limit.
	if (ENHANCED) begin : g_enh
		assign zero_cross_high_voltage_enable = cfg_q.shared_54;
		assign booster_multiphase_select = 2'h0;
	end else begin : g_base
		assign zero_cross_high_voltage_enable = 2'h0;
		assign booster_multiphase_select = cfg_q.shared_54;
	end

endmodule

// *** rtl/ldpwm_pkg.sv ***
// Constants, field layout and configuration struct of the LED dimming PWM block.
package ldpwm_pkg;

	// ----------------------------------------------------------------
	// Register indices; the APB byte address is four times the index.
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_DIM_GENERAL_CONFIG = 8'h08;
	localparam logic [7:0] IDX_DUTY_LEVEL_CHANNEL_ONE = 8'h09;
	localparam logic [7:0] IDX_DIM_STATUS = 8'h1F;
	localparam int ADDR_LSB = 2;

	// ----------------------------------------------------------------
	// Widths and reset values.
	// ----------------------------------------------------------------
	localparam int REG_W = 10;
	localparam int DUTY_W = 10;
	localparam logic [9:0] DIM_GENERAL_CONFIG_RST = 10'h000;
	localparam logic [9:0] DUTY_LEVEL_CHANNEL_ONE_RST = 10'h000;

	// ----------------------------------------------------------------
	// Field positions of the general configuration register.
	// ----------------------------------------------------------------
	localparam int RATE_SEL_LSB = 0;
	localparam int SRC_SEL_LSB = 2;
	localparam int SHARED_54_LSB = 4;
	localparam int DRIVE_TGT_LSB = 6;

	// Dimming source encodings; any code other than internal picks the external input.
	localparam logic [1:0] DIMMING_SOURCE_SELECT_INTERNAL = 2'h0;

	// Status register bit positions.
	localparam int STAT_LEVEL_BIT = 0;
	localparam int STAT_EXT_BIT = 1;
	localparam int STAT_ENH_BIT = 2;

	// ----------------------------------------------------------------
	// Timing: clock rate and default step dividers of the four dimming rates.
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_MHZ = 100;
	localparam int DIM_DIV_RATE0 = 4;
	localparam int DIM_DIV_RATE1 = 8;
	localparam int DIM_DIV_RATE2 = 16;
	localparam int DIM_DIV_RATE3 = 32;
	localparam int DIV_W = 16;

	// Layout matches bits [9:0] of the general configuration register.
	typedef struct packed {
		logic [3:0] gate_drive_voltage_target;
		logic [1:0] shared_54;
		logic [1:0] dimming_source_select;
		logic [1:0] internal_dim_rate_select;
	} ldpwm_cfg_s;

endpackage

// *** rtl/ldpwm_dim_gen.sv ***
// Internal dimming waveform generator with a period of 2**W-1 steps.
`timescale 1ns/1ps
module ldpwm_dim_gen #(
	parameter int W = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic step_en,
	input wire logic [W-1:0] duty,
	output logic level_q,
	output logic period_start_q
);

	localparam logic [W-1:0] LAST_STEP = {{(W-1){1'b1}}, 1'b0};

	logic [W-1:0] cnt_q;
	logic [W-1:0] duty_act_q;

	// ----------------------------------------------------------------
	// Step counter and period-aligned duty capture.
	// ----------------------------------------------------------------
	// Duty is taken only at a period boundary so a write never yields a runt pulse.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			duty_act_q <= '0;
			period_start_q <= 1'b0;
		end else begin
			period_start_q <= 1'b0;
			if (step_en) begin
				if (cnt_q == LAST_STEP) begin
					cnt_q <= '0;
					duty_act_q <= duty;
					period_start_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Output level.
	// ----------------------------------------------------------------
	// Counts run 0..2**W-2, so the full-scale code keeps the output on throughout.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= 1'b0;
		end else begin
			level_q <= (cnt_q < duty_act_q);
		end
	end

endmodule

// *** tb/ldpwm_asserts.sv ***
// Port-level assertion checker for the LED dimming PWM block.
`timescale 1ns/1ps
module ldpwm_asserts #(
	parameter bit ENHANCED = 1'b1,
	parameter int DIV_RATE3 = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ext_dim_ch1,
	input wire logic dim_ch1,
	input wire logic [1:0] zero_cross_high_voltage_enable,
	input wire logic [1:0] booster_multiphase_select,
	input wire logic [3:0] gate_drive_voltage_target
);
	// ----------------------------------------------------------------
	// Mirror of the writable registers.
	// ----------------------------------------------------------------
	// One period at the slowest rate plus a divider reload, so a late duty latch has settled.
	localparam int LIM = 1024 * DIV_RATE3 + 8;
	logic wr;
	logic ext_q;
	logic [9:0] m;
	logic [9:0] cfg_q;
	logic [9:0] duty_q;
	int cnt_q;
	assign wr = psel && penable && pready && pwrite && !pslverr;
	assign m = {{2{pstrb[1]}}, {8{pstrb[0]}}};
	assign ext_q = cfg_q[3:2] != 2'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= 10'h000;
			duty_q <= 10'h000;
		end else if (wr && paddr[11:2] == 10'h008) begin
			cfg_q <= (cfg_q & ~m) | (pwdata[9:0] & m);
		end else if (wr && paddr[11:2] == 10'h009) begin
			duty_q <= (duty_q & ~m) | (pwdata[9:0] & m);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 0;
		end else if (ext_q || wr || (duty_q != 10'h000 && duty_q != 10'h3FF)) begin
			cnt_q <= 0;
		end else if (cnt_q < LIM) begin
			cnt_q <= cnt_q + 1;
		end
	end
	// ----------------------------------------------------------------
	// Properties.
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_PREADY_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("pready not after exactly one wait cycle");
	AST_ERR_PAIR: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_UNMAPPED: assert property (psel && penable && pready && paddr[11:10] != 2'h0 |-> pslverr)
		else $error("unmapped access not refused");
	AST_IDLE_RDATA: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero outside an answer");
	AST_RDATA_UPPER: assert property (pready |-> prdata[31:10] == 22'h0)
		else $error("prdata upper bits not zero");
	AST_STAT_SRC: assert property (pready && !pwrite && paddr == 12'h07C |-> prdata[1] == ext_q)
		else $error("status source bit wrong");
	AST_GATE: assert property (gate_drive_voltage_target == cfg_q[9:6])
		else $error("drive target does not follow config");
	AST_ZCD: assert property (zero_cross_high_voltage_enable == (ENHANCED ? cfg_q[5:4] : 2'h0))
		else $error("zero-cross enable does not follow config");
	AST_MULTI_ZERO: assert property (booster_multiphase_select == (ENHANCED ? 2'h0 : cfg_q[5:4]))
		else $error("multiphase select does not match the variant");
	AST_EXT_FOLLOW: assert property (ext_q && $past(ext_q) |-> dim_ch1 == $past(ext_dim_ch1))
		else $error("output does not follow external input");
	AST_LEVEL: assert property (cnt_q >= LIM |-> dim_ch1 == (duty_q == 10'h3FF))
		else $error("full or zero duty level wrong");
endmodule

bind ldpwm_top ldpwm_asserts #(.ENHANCED(ENHANCED), .DIV_RATE3(DIV_RATE3)) u_chk (
	.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ext_dim_ch1(ext_dim_ch1), .dim_ch1(dim_ch1),
	.zero_cross_high_voltage_enable(zero_cross_high_voltage_enable),
	.booster_multiphase_select(booster_multiphase_select),
	.gate_drive_voltage_target(gate_drive_voltage_target));

// *** tb/tb_top.sv ***
// Self-checking testbench of the LED dimming PWM block.
`timescale 1ns/1ps
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic ext_dim_ch1 = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic dim_ch1;
	logic [1:0] zcd;
	logic [1:0] multi;
	logic [3:0] gate;
	logic [1:0] zcd_b;
	logic [1:0] multi_b;
	logic [31:0] rd;
	logic er;
	logic [9:0] v;
	int n_fail = 0;
	int checked = 0;
	localparam logic [11:0] A_CFG = {2'h0, ldpwm_pkg::IDX_DIM_GENERAL_CONFIG, 2'h0};
	localparam logic [11:0] A_DUTY = {2'h0, ldpwm_pkg::IDX_DUTY_LEVEL_CHANNEL_ONE, 2'h0};
	localparam logic [11:0] A_STAT = {2'h0, ldpwm_pkg::IDX_DIM_STATUS, 2'h0};
	always #5 pclk = ~pclk;
	// Small, distinct dividers keep dimming periods short and tell the rate codes apart.
	ldpwm_top #(.DIV_RATE0(1), .DIV_RATE1(2), .DIV_RATE2(3), .DIV_RATE3(4)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_dim_ch1(ext_dim_ch1), .dim_ch1(dim_ch1),
		.zero_cross_high_voltage_enable(zcd), .booster_multiphase_select(multi),
		.gate_drive_voltage_target(gate));
	// Base variant on the same bus; its software keeps the multiphase field at zero.
	ldpwm_top #(.ENHANCED(1'b0), .DIV_RATE0(1), .DIV_RATE1(2), .DIV_RATE2(3),
		.DIV_RATE3(4)) dut_base (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata((paddr == A_CFG) ? (pwdata & ~32'h00000030) : pwdata),
		.pstrb(pstrb), .prdata(), .pready(), .pslverr(), .ext_dim_ch1(ext_dim_ch1), .dim_ch1(),
		.zero_cross_high_voltage_enable(zcd_b), .booster_multiphase_select(multi_b),
		.gate_drive_voltage_target());
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Any window of one whole period holds exactly duty high steps.
	task automatic highs(input int n, input logic [31:0] exp);
		int c;
		c = 0;
		repeat (4200) @(posedge pclk);
		repeat (n) begin
			@(posedge pclk);
			c += (dim_ch1 === 1'b1);
		end
		chk(c, exp);
	endtask
	task automatic results;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		#500000;
		n_fail++;
		results();
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, A_CFG, 32'h0, 4'hF);
		chk(rd, 32'h0);
		apb(1'b0, A_DUTY, 32'h0, 4'hF);
		chk(rd, 32'h0);
		apb(1'b0, A_STAT, 32'h0, 4'hF);
		chk(rd, 32'h4);
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			v = {4'(i), 2'(i), 2'(i >> 2), 2'(i)};
			apb(1'b1, A_CFG, {22'h0, v}, 4'hF);
			apb(1'b0, A_CFG, 32'h0, 4'hF);
			chk(rd, {22'h0, v});
			chk({gate, multi, zcd}, {v[9:6], 2'h0, v[5:4]});
			chk({multi_b, zcd_b}, 4'h0);
			apb(1'b0, A_STAT, 32'h0, 4'hF);
			chk(rd[2:1], {1'b1, v[3:2] != 2'h0});
		end
		$display("test config done");
		apb(1'b1, 12'hC00, 32'h3FF, 4'hF);
		chk(er, 1'b1);
		apb(1'b0, 12'h040, 32'h0, 4'hF);
		chk({er, rd}, {1'b1, 32'h0});
		apb(1'b1, A_DUTY, 32'h3FF, 4'hF);
		apb(1'b1, A_DUTY, 32'h0, 4'h1);
		apb(1'b0, A_DUTY, 32'h0, 4'hF);
		chk(rd, 32'h300);
		apb(1'b1, A_DUTY, 32'h3FF, 4'h2);
		apb(1'b0, A_DUTY, 32'h0, 4'hF);
		chk(rd, 32'h300);
		$display("test refusal done");
		apb(1'b1, A_CFG, 32'h004, 4'hF);
		apb(1'b1, A_DUTY, 32'h3FF, 4'hF);
		ext_dim_ch1 <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(dim_ch1, 1'b1);
		ext_dim_ch1 <= 1'b0;
		repeat (4) @(posedge pclk);
		chk(dim_ch1, 1'b0);
		$display("test external done");
		apb(1'b1, A_CFG, 32'h000, 4'hF);
		highs(1023, 1023);
		apb(1'b1, A_DUTY, 32'h000, 4'hF);
		highs(1023, 0);
		apb(1'b1, A_DUTY, 32'h155, 4'hF);
		highs(1023, 341);
		apb(1'b1, A_CFG, 32'h002, 4'hF);
		highs(3069, 1023);
		apb(1'b1, A_CFG, 32'h003, 4'hF);
		highs(4092, 1364);
		$display("test internal done");
		results();
	end
endmodule
